//--- hdl/us2_pkg.sv
package us2_pkg;

	localparam int ADR_W = 4;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;

	// byte addresses of the word-wide registers
	localparam logic [ADR_W-1:0] OFS_S2 = 4'h0;
	localparam logic [ADR_W-1:0] OFS_CTRL = 4'h4;
	localparam logic [ADR_W-1:0] OFS_IRQ_ST = 4'h8;
	localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 4'hc;

	// serial_status_two fields, msb first, bit 5 reads zero
	typedef struct packed {
		logic line_break_detect_flag;
		logic rx_edge_flag;
		logic rsvd;
		logic rx_polarity_invert;
		logic wake_idle_flag_select;
		logic long_break_tx;
		logic line_break_detect_enable;
		logic receiver_active_flag;
	} us2_s2_s;

	localparam logic [7:0] S2_RST = 8'h00;

	// control register bit positions
	localparam int CTRL_NINE = 0;
	localparam int CTRL_TWO_STOP = 1;
	localparam int CTRL_STANDBY = 2;
	localparam int CTRL_SEND_BREAK = 3;
	localparam int CTRL_W = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

	// event bits of the interrupt status and mask registers
	localparam int EV_BREAK = 0;
	localparam int EV_EDGE = 1;
	localparam int EV_IDLE = 2;
	localparam int EV_FE = 3;
	localparam int EV_FULL = 4;
	localparam int EV_W = 5;
	localparam logic [EV_W-1:0] EV_RST = 5'h00;

	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] BASE_FRAME_BITS = 4'ha;
	localparam logic [CNT_W-1:0] LONG_BREAK_EXTRA = 4'h3;
	localparam logic [CNT_W-1:0] DATA_BITS_BASE = 4'h8;
	localparam logic [CNT_W-1:0] ONE_BIT = 4'h1;

	localparam int CLK_HZ = 50_000_000;
	localparam int BAUD_DEFAULT = 115_200;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [ADR_W-1:0] adr;
		logic [SEL_W-1:0] sel;
		logic [DAT_W-1:0] dat;
	} us2_wb_req_s;

	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} us2_rx_state_e;

	// character length in bit times plus an extra amount
	function automatic logic [CNT_W-1:0] frame_bits(
		input logic nine,
		input logic two_stop,
		input logic [CNT_W-1:0] extra
	);
		frame_bits = BASE_FRAME_BITS + {3'h0, nine} + {3'h0, two_stop}
			+ extra;
	endfunction : frame_bits

endpackage : us2_pkg

//--- hdl/us2_sync.sv
`timescale 1ns/1ps

module us2_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o
);

	logic meta_reg;

	// first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end

endmodule : us2_sync

//--- hdl/us2_baud.sv
`timescale 1ns/1ps

module us2_baud #(
	parameter int BIT_CYCLES = 434
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic restart_i,
	input wire logic load_half_i,
	output logic tick_o
);

	localparam int CW = $clog2(BIT_CYCLES);
	localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
	// the registered tick costs a cycle, so loads after a restart run short
	localparam logic [CW-1:0] FIRST = CW'(BIT_CYCLES - 2);
	localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2 - 2);

	logic [CW-1:0] cnt_reg;

	initial begin
		if (BIT_CYCLES < 4) begin
			$error("us2_baud: BIT_CYCLES must be at least 4");
		end
	end

	// free running, so idle and break counts see ticks without a frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= FULL;
			tick_o <= 1'b0;
		end else if (restart_i) begin
			cnt_reg <= load_half_i ? HALF : FIRST;
			tick_o <= 1'b0;
		end else if (cnt_reg == '0) begin
			cnt_reg <= FULL;
			tick_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg - 1'b1;
			tick_o <= 1'b0;
		end
	end

endmodule : us2_baud

//--- hdl/us2_top.sv
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps

module us2_top #(
	parameter int CLK_HZ = us2_pkg::CLK_HZ,
	parameter int BAUD_RATE = us2_pkg::BAUD_DEFAULT
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire us2_pkg::us2_wb_req_s wb_req_i,
	output logic [us2_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic serial_rx_pin_i,
	output logic serial_tx_o,
	output logic irq_o
);

	localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
	localparam int CW = us2_pkg::CNT_W;

	initial begin
		if (BIT_CYCLES < 4) begin
			$error("us2_top: clock too slow for the chosen baud rate");
		end
	end

	us2_pkg::us2_s2_s s2_reg;
	logic [us2_pkg::CTRL_W-1:0] ctrl_reg;
	logic [us2_pkg::EV_W-1:0] irq_st_reg;
	logic [us2_pkg::EV_W-1:0] irq_mask_reg;
	logic [us2_pkg::EV_W-1:0] ev_vec;

	us2_pkg::us2_rx_state_e rx_state_reg;
	logic [CW-1:0] bit_cnt_reg;
	logic [CW-1:0] low_cnt_reg;
	logic [CW-1:0] high_cnt_reg;
	logic stop_bad_reg;
	logic rx_sync;
	logic rx_line;
	logic rx_line_d_reg;
	logic rx_tick;
	logic rx_fall;
	logic rx_restart;
	logic rx_sample;

	logic tx_busy_reg;
	logic [CW-1:0] tx_cnt_reg;
	logic tx_tick;
	logic tx_start;
	logic tx_done;

	logic wb_access;
	logic wb_wr;
	logic wr_s2;
	logic wr_ctrl;
	logic wr_irq_st;
	logic wr_irq_mask;
	logic [7:0] wdat;

	logic nine_bit_select;
	logic two_stop_select;
	logic receive_standby;
	logic [CW-1:0] data_bits;
	logic [CW-1:0] stop_bits;
	logic [CW-1:0] frame_len;
	logic [CW-1:0] break_thr;
	logic [CW-1:0] tx_len;

	logic start_ok;
	logic frame_end;
	logic ev_fe;
	logic ev_full;
	logic break_hit;
	logic idle_hit;
	logic idle_flag_set;
	logic break_flag_set;

	// bus decode: a write takes effect at the edge where the master sees ack
	assign wb_access = wb_req_i.cyc & wb_req_i.stb;
	assign wb_wr = wb_access & wb_req_i.we & wb_ack_o & wb_req_i.sel[0];
	assign wdat = wb_req_i.dat[7:0];
	assign wr_s2 = wb_wr & (wb_req_i.adr == us2_pkg::OFS_S2);
	assign wr_ctrl = wb_wr & (wb_req_i.adr == us2_pkg::OFS_CTRL);
	assign wr_irq_st = wb_wr & (wb_req_i.adr == us2_pkg::OFS_IRQ_ST);
	assign wr_irq_mask = wb_wr & (wb_req_i.adr == us2_pkg::OFS_IRQ_MASK);

	assign nine_bit_select = ctrl_reg[us2_pkg::CTRL_NINE];
	assign two_stop_select = ctrl_reg[us2_pkg::CTRL_TWO_STOP];
	assign receive_standby = ctrl_reg[us2_pkg::CTRL_STANDBY];

	// framing lengths; long_break_tx only reaches the transmit length
	assign data_bits = us2_pkg::DATA_BITS_BASE + {3'h0, nine_bit_select};
	assign stop_bits = us2_pkg::ONE_BIT + {3'h0, two_stop_select};
	assign frame_len = us2_pkg::frame_bits(nine_bit_select, two_stop_select,
		'0);
	assign break_thr = us2_pkg::frame_bits(nine_bit_select, two_stop_select,
		{3'h0, s2_reg.line_break_detect_enable});
	assign tx_len = us2_pkg::frame_bits(nine_bit_select, two_stop_select,
		s2_reg.long_break_tx ? us2_pkg::LONG_BREAK_EXTRA : '0);

	us2_sync #(
		.RST_VAL(1'b1)
	) u_rx_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(serial_rx_pin_i),
		.q_o(rx_sync)
	);

	// inversion sits ahead of every receive path
	assign rx_line = rx_sync ^ s2_reg.rx_polarity_invert;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_line_d_reg <= 1'b1;
		end else begin
			rx_line_d_reg <= rx_line;
		end
	end

	// a falling edge of the inverted line is the pin's active edge
	assign rx_fall = rx_line_d_reg & ~rx_line;
	assign rx_restart = (rx_state_reg == us2_pkg::RX_IDLE) & rx_fall;
	// a free tick on the restart edge would add a sample ahead of the start
	assign rx_sample = rx_tick & ~rx_restart;

	us2_baud #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_rx_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(rx_restart),
		.load_half_i(1'b1),
		.tick_o(rx_tick)
	);

	// receive frame tracking
	assign start_ok = (rx_state_reg == us2_pkg::RX_START) & rx_tick & ~rx_line;
	assign frame_end = (rx_state_reg == us2_pkg::RX_STOP) & rx_tick
		& (bit_cnt_reg == stop_bits - us2_pkg::ONE_BIT);
	assign ev_fe = frame_end & (stop_bad_reg | ~rx_line)
		& ~s2_reg.line_break_detect_enable;
	assign ev_full = frame_end & ~s2_reg.line_break_detect_enable;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_state_reg <= us2_pkg::RX_IDLE;
			bit_cnt_reg <= '0;
			stop_bad_reg <= 1'b0;
		end else begin
			unique case (rx_state_reg)
				us2_pkg::RX_IDLE: begin
					if (rx_fall) begin
						rx_state_reg <= us2_pkg::RX_START;
					end
				end
				us2_pkg::RX_START: begin
					if (rx_tick) begin
						// a glitch shorter than half a bit is no start
						rx_state_reg <= rx_line ? us2_pkg::RX_IDLE
							: us2_pkg::RX_DATA;
						bit_cnt_reg <= '0;
					end
				end
				us2_pkg::RX_DATA: begin
					if (rx_tick) begin
						if (bit_cnt_reg == data_bits - us2_pkg::ONE_BIT) begin
							rx_state_reg <= us2_pkg::RX_STOP;
							bit_cnt_reg <= '0;
							stop_bad_reg <= 1'b0;
						end else begin
							bit_cnt_reg <= bit_cnt_reg + us2_pkg::ONE_BIT;
						end
					end
				end
				us2_pkg::RX_STOP: begin
					if (rx_tick) begin
						stop_bad_reg <= stop_bad_reg | ~rx_line;
						bit_cnt_reg <= bit_cnt_reg + us2_pkg::ONE_BIT;
						if (frame_end) begin
							rx_state_reg <= us2_pkg::RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// run lengths saturate at their threshold so each hit fires once
	assign break_hit = rx_sample & ~rx_line & (low_cnt_reg != break_thr)
		& (low_cnt_reg + us2_pkg::ONE_BIT == break_thr);
	assign idle_hit = rx_sample & rx_line & (high_cnt_reg != frame_len)
		& (high_cnt_reg + us2_pkg::ONE_BIT == frame_len);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_cnt_reg <= '0;
			high_cnt_reg <= '0;
		end else if (rx_sample) begin
			if (rx_line) begin
				low_cnt_reg <= '0;
				if (high_cnt_reg != frame_len) begin
					high_cnt_reg <= high_cnt_reg + us2_pkg::ONE_BIT;
				end
			end else begin
				high_cnt_reg <= '0;
				if (low_cnt_reg != break_thr) begin
					low_cnt_reg <= low_cnt_reg + us2_pkg::ONE_BIT;
				end
			end
		end
	end

	assign break_flag_set = break_hit & s2_reg.line_break_detect_enable;
	// an idle that wakes the receiver from standby may stay silent
	assign idle_flag_set = idle_hit
		& (~receive_standby | s2_reg.wake_idle_flag_select);

	// serial_status_two: hardware sets win over a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s2_reg <= us2_pkg::S2_RST;
		end else begin
			if (break_flag_set) begin
				s2_reg.line_break_detect_flag <= 1'b1;
			end else if (wr_s2 & wdat[7]) begin
				s2_reg.line_break_detect_flag <= 1'b0;
			end
			if (rx_fall) begin
				s2_reg.rx_edge_flag <= 1'b1;
			end else if (wr_s2 & wdat[6]) begin
				s2_reg.rx_edge_flag <= 1'b0;
			end
			s2_reg.rsvd <= 1'b0;
			if (wr_s2) begin
				s2_reg.rx_polarity_invert <= wdat[4];
				s2_reg.wake_idle_flag_select <= wdat[3];
				s2_reg.long_break_tx <= wdat[2];
				s2_reg.line_break_detect_enable <= wdat[1];
			end
			if (start_ok) begin
				s2_reg.receiver_active_flag <= 1'b1;
			end else if (idle_hit) begin
				s2_reg.receiver_active_flag <= 1'b0;
			end
		end
	end

	// control: send_break starts a break and clears itself at its end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= us2_pkg::CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= wdat[us2_pkg::CTRL_W-1:0]
					| {ctrl_reg[us2_pkg::CTRL_SEND_BREAK] & ~tx_done, 3'h0};
			end else if (tx_done) begin
				ctrl_reg[us2_pkg::CTRL_SEND_BREAK] <= 1'b0;
			end
		end
	end

	// break transmitter
	assign tx_start = ~tx_busy_reg & ctrl_reg[us2_pkg::CTRL_SEND_BREAK];
	assign tx_done = tx_busy_reg & tx_tick & (tx_cnt_reg == us2_pkg::ONE_BIT);

	us2_baud #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_tx_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(tx_start),
		.load_half_i(1'b0),
		.tick_o(tx_tick)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_busy_reg <= 1'b0;
			tx_cnt_reg <= '0;
			serial_tx_o <= 1'b1;
		end else if (tx_start) begin
			tx_busy_reg <= 1'b1;
			tx_cnt_reg <= tx_len;
			serial_tx_o <= 1'b0;
		end else if (tx_busy_reg & tx_tick) begin
			tx_cnt_reg <= tx_cnt_reg - us2_pkg::ONE_BIT;
			if (tx_done) begin
				tx_busy_reg <= 1'b0;
				serial_tx_o <= 1'b1;
			end
		end
	end

	// interrupt status: sticky, write one to clear, event beats clear
	assign ev_vec = {ev_full, ev_fe, idle_flag_set, rx_fall, break_flag_set};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_st_reg <= us2_pkg::EV_RST;
		end else if (wr_irq_st) begin
			irq_st_reg <= (irq_st_reg & ~wdat[us2_pkg::EV_W-1:0]) | ev_vec;
		end else begin
			irq_st_reg <= irq_st_reg | ev_vec;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_reg <= us2_pkg::EV_RST;
		end else if (wr_irq_mask) begin
			irq_mask_reg <= wdat[us2_pkg::EV_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_st_reg & irq_mask_reg);
		end
	end

	// bus answer: ack one cycle after the request, read data with it
	function automatic logic [us2_pkg::DAT_W-1:0] read_mux(
		input logic [us2_pkg::ADR_W-1:0] adr
	);
		read_mux = '0;
		unique case (adr)
			us2_pkg::OFS_S2: read_mux[7:0] = s2_reg;
			us2_pkg::OFS_CTRL: read_mux[us2_pkg::CTRL_W-1:0] = ctrl_reg;
			us2_pkg::OFS_IRQ_ST: read_mux[us2_pkg::EV_W-1:0] = irq_st_reg;
			us2_pkg::OFS_IRQ_MASK: read_mux[us2_pkg::EV_W-1:0] = irq_mask_reg;
			default: read_mux = '0;
		endcase
	endfunction : read_mux

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_access & ~wb_ack_o;
			if (wb_access & ~wb_ack_o) begin
				wb_dat_o <= read_mux(wb_req_i.adr);
			end
		end
	end

endmodule : us2_top

//--- dv/us2_props.sv
`timescale 1ns/1ps

module us2_props #(
	parameter int CLK_HZ = 50_000_000,
	parameter int BAUD_RATE = 115_200
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire us2_pkg::us2_wb_req_s wb_req_i,
	input wire logic [us2_pkg::DAT_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic serial_rx_pin_i,
	input wire logic serial_tx_o,
	input wire logic irq_o
);
	localparam int B = CLK_HZ / BAUD_RATE;
	int low_q;
	logic req;
	logic rd_s2;
	assign req = wb_req_i.cyc & wb_req_i.stb;
	assign rd_s2 = wb_ack_o & !wb_req_i.we
		& (wb_req_i.adr == us2_pkg::OFS_S2);
	// length of the current low stretch on the transmit line
	always_ff @(posedge clk_i) begin
		if (rst_i || serial_tx_o) low_q <= 0;
		else low_q <= low_q + 1;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held longer than one cycle");
	property p_ack_cause;
		req && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("request not answered next cycle");
	property p_ack_only;
		wb_ack_o |-> $past(req);
	endproperty
	a_ack_only: assert property (p_ack_only)
		else $error("ack without request");
	property p_rsvd;
		rd_s2 |-> !wb_dat_o[5];
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bit read as one");
	property p_dat_hi;
		wb_ack_o && !wb_req_i.we |-> wb_dat_o[31:8] == 24'h000000;
	endproperty
	a_dat_hi: assert property (p_dat_hi)
		else $error("upper read data not zero");
	property p_reset_out;
		$fell(rst_i) |-> !irq_o && serial_tx_o && !wb_ack_o;
	endproperty
	a_reset_out: assert property (p_reset_out)
		else $error("outputs not idle after reset");
	property p_brk_len;
		$rose(serial_tx_o) && !$past(rst_i) |-> low_q % B == 0
			&& low_q >= 10 * B && low_q <= 15 * B;
	endproperty
	a_brk_len: assert property (p_brk_len)
		else $error("break length not a legal bit count");
	property p_brk_max;
		low_q <= 15 * B;
	endproperty
	a_brk_max: assert property (p_brk_max)
		else $error("transmit low too long");
	c_write: cover property (wb_ack_o && wb_req_i.we);
	c_break: cover property ($rose(serial_tx_o));
	c_irq: cover property ($rose(irq_o));
endmodule : us2_props

bind us2_top us2_props #(.CLK_HZ(CLK_HZ), .BAUD_RATE(BAUD_RATE)) u_us2_props (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_req_i(wb_req_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.serial_rx_pin_i(serial_rx_pin_i),
	.serial_tx_o(serial_tx_o),
	.irq_o(irq_o)
);

//--- dv/us2_node.sv
`timescale 1ns/1ps

module us2_node #(
	parameter int B = 10
) (
	input wire logic clk_i,
	output logic rx_o
);
	logic inv = 1'b0;
	initial rx_o = 1'b1;
	// levels are line levels; inv mirrors a receiver set to invert
	task automatic hold(input logic v, input int n);
		@(posedge clk_i);
		rx_o <= v ^ inv;
		repeat (n * B - 1) @(posedge clk_i);
	endtask : hold
	task automatic low_run(input int n);
		hold(1'b0, n);
		hold(1'b1, 14);
	endtask : low_run
	task automatic frame(input logic [7:0] d);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) hold(d[i], 1);
		hold(1'b1, 1);
	endtask : frame
endmodule : us2_node

//--- dv/test_us2_top.sv
`timescale 1ns/1ps

module test_us2_top;
	localparam int B = 10;
	localparam logic [3:0] S2 = us2_pkg::OFS_S2;
	localparam logic [3:0] CT = us2_pkg::OFS_CTRL;
	localparam logic [3:0] IS = us2_pkg::OFS_IRQ_ST;
	localparam logic [3:0] IM = us2_pkg::OFS_IRQ_MASK;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	us2_pkg::us2_wb_req_s wb_req_i = '0;
	logic [31:0] wb_dat_o;
	logic [31:0] rd;
	logic wb_ack_o;
	logic rx;
	logic serial_tx_o;
	logic irq_o;
	int fail_count = 0;
	int check_count = 0;
	int seed = 32'ha4af92d4;
	int n;
	int w;
	always #10 clk_i = ~clk_i;
	us2_top #(.BAUD_RATE(5_000_000)) u_us2_top (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_req_i(wb_req_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.serial_rx_pin_i(rx),
		.serial_tx_o(serial_tx_o),
		.irq_o(irq_o)
	);
	us2_node #(.B(B)) u_us2_node (
		.clk_i(clk_i),
		.rx_o(rx)
	);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [3:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		wb_req_i <= '{1'b1, 1'b1, we, a, 4'hf, d};
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 50);
		rd = wb_dat_o;
		wb_req_i <= '0;
		if (t >= 50) chk(32'h0, 32'h1);
	endtask : wb
	task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdchk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_sim
	initial begin
		#400_000;
		fail_count++;
		end_sim();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 4; i++) rdchk(4'(i * 4), 32'h0);
		wb(1'b1, S2, 32'hef);
		rdchk(S2, 32'h0e);
		wb(1'b1, S2, 32'h00);
		u_us2_node.low_run(1);
		rdchk(S2, 32'h40);
		wb(1'b1, S2, 32'h00);
		rdchk(S2, 32'h40);
		wb(1'b1, S2, 32'h40);
		rdchk(S2, 32'h00);
		// invert first so the pin swing below is seen as a line rise
		wb(1'b1, S2, 32'h10);
		u_us2_node.inv = 1'b1;
		u_us2_node.hold(1'b1, 12);
		wb(1'b1, S2, 32'hd0);
		u_us2_node.low_run(1);
		rdchk(S2, 32'h50);
		// drop inversion before the pin returns high, so no long low is seen
		wb(1'b1, S2, 32'hc0);
		u_us2_node.inv = 1'b0;
		u_us2_node.hold(1'b1, 14);
		for (int k = 0; k < 4; k++) begin
			n = 11 + k % 2 + k / 2;
			wb(1'b1, CT, 32'(k));
			wb(1'b1, S2, 32'h42);
			wb(1'b1, IS, 32'h1f);
			u_us2_node.low_run(n - 1);
			rdchk(S2, 32'h42);
			rdchk(IS, 32'h06);
			wb(1'b1, IS, 32'h1f);
			u_us2_node.low_run(n);
			rdchk(S2, 32'hc2);
			rdchk(IS, 32'h07);
			wb(1'b1, S2, 32'h02);
			rdchk(S2, 32'hc2);
			wb(1'b1, S2, 32'hc2);
			rdchk(S2, 32'h02);
		end
		wb(1'b1, CT, 32'h0);
		wb(1'b1, S2, 32'h04);
		wb(1'b1, IS, 32'h1f);
		u_us2_node.low_run(12);
		rdchk(S2, 32'h44);
		rdchk(IS, 32'h1e);
		for (int k = 0; k < 3; k++) begin
			w = (k == 2) ? 32'h08 : 32'h00;
			wb(1'b1, CT, (k != 0) ? 32'h4 : 32'h0);
			wb(1'b1, S2, 32'h40 | w);
			wb(1'b1, IS, 32'h1f);
			fork
				u_us2_node.frame(8'($random(seed)));
				begin
					repeat (3 * B) @(posedge clk_i);
					rdchk(S2, 32'h41 | w);
				end
			join
			u_us2_node.hold(1'b1, 11);
			rdchk(S2, 32'h40 | w);
			rdchk(IS, (k == 1) ? 32'h12 : 32'h16);
		end
		for (int k = 0; k < 8; k++) begin
			wb(1'b1, S2, (k / 4 != 0) ? 32'h04 : 32'h00);
			wb(1'b1, CT, 32'h8 | 32'(k % 4));
			n = 0;
			while (serial_tx_o !== 1'b0 && n < 50) begin
				@(posedge clk_i);
				n++;
			end
			n = 0;
			while (serial_tx_o === 1'b0 && n < 400) begin
				@(posedge clk_i);
				n++;
			end
			chk(n, (10 + k % 2 + (k / 2) % 2 + 3 * (k / 4)) * B);
		end
		wb(1'b1, CT, 32'h0);
		wb(1'b1, IS, 32'h1f);
		wb(1'b1, IM, 32'h02);
		u_us2_node.low_run(1);
		chk(irq_o, 1'b1);
		wb(1'b1, IM, 32'h00);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b0);
		wb(1'b1, IM, 32'h02);
		wb(1'b1, IS, 32'h02);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b0);
		end_sim();
	end
endmodule : test_us2_top
